// File: inc/srd_pkg.sv
// Constants, types and decode helpers for the serial RGB destuffer.
// Assumes nothing of its surroundings; it holds no logic of its own.
`default_nettype none
package srd_pkg;

	// ------------------------------
	// Character framing
	// ------------------------------
	localparam int         CHAR_BITS = 10;
	localparam int         PIX_BITS  = 8;
	localparam int         DAC_BITS  = 10;
	localparam logic [3:0] BIT_LAST  = 4'h9;  // Index of the tenth bit.
	localparam logic [3:0] BIT_SAT   = 4'hF;  // Bit counter ceiling.
	localparam logic [1:0] DAC_PAD   = 2'h0;  // Low DAC bits left idle.

	// Fill character that stuffs unused slots.
	localparam logic [9:0] FILL_CHAR = 10'h07A;

	// Blanking tokens, named by the vsync and hsync they carry.
	localparam logic [9:0] CTL_V0H0 = 10'h354;
	localparam logic [9:0] CTL_V0H1 = 10'h0AB;
	localparam logic [9:0] CTL_V1H0 = 10'h154;
	localparam logic [9:0] CTL_V1H1 = 10'h2AB;

	// ------------------------------
	// Lane skew tolerance
	// ------------------------------
	localparam int SKEW_PS       = 2000; // Worst lane to lane skew.
	localparam int BIT_PS_MIN    = 500;  // Shortest bit time.
	localparam int SKEW_BITS_DEF = (SKEW_PS + BIT_PS_MIN - 1) / BIT_PS_MIN;

	// ------------------------------
	// Modes and states
	// ------------------------------
	typedef enum logic [1:0] {
		MULT_1X = 2'h0,
		MULT_2X = 2'h1,
		MULT_4X = 2'h3
	} srd_mult_t;
	localparam logic [1:0] SLOT_LAST_1X = 2'h0;
	localparam logic [1:0] SLOT_LAST_2X = 2'h1;
	localparam logic [1:0] SLOT_LAST_4X = 2'h3;

	typedef enum logic [1:0] {
		LK_SEARCH  = 2'h0,
		LK_CONFIRM = 2'h1,
		LK_LOCKED  = 2'h3
	} srd_lock_t;

	// True for any of the four blanking tokens.
	function automatic logic srd_is_ctl(input logic [9:0] c);
		return (c == CTL_V0H0) || (c == CTL_V0H1) ||
			(c == CTL_V1H0) || (c == CTL_V1H1);
	endfunction : srd_is_ctl

	// Returns {vsync, hsync} carried by a blanking token.
	function automatic logic [1:0] srd_ctl_vh(input logic [9:0] c);
		return {(c == CTL_V1H0) || (c == CTL_V1H1),
			(c == CTL_V0H1) || (c == CTL_V1H1)};
	endfunction : srd_ctl_vh

	// Undoes the transition-minimising code of a data character.
	function automatic logic [7:0] srd_decode(input logic [9:0] c);
		logic [7:0] d;
		logic [7:0] q;
		d = c[9] ? ~c[7:0] : c[7:0];
		q[0] = d[0];
		for (int i = 1; i < PIX_BITS; i++) begin
			q[i] = c[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
		end
		return q;
	endfunction : srd_decode

endpackage : srd_pkg
`default_nettype wire

// File: hw/srd_lane.sv
// One colour lane: deserialiser and bit-offset aligner on the link clock.
// Assumes bit_in and char_start come from registers on lclk.
`timescale 1ns/100ps
`default_nettype none
module srd_lane
	import srd_pkg::*;
#(
	parameter int SKEW_BITS = SKEW_BITS_DEF // Offsets searched in bits.
) (
	input  wire logic       lclk,       // Link bit clock.
	input  wire logic       lrst_n,     // Link reset, active low.
	input  wire logic       bit_in,     // Registered serial bit.
	input  wire logic       char_start, // Bit zero arrives this cycle.
	input  wire logic       char_tick,  // Cycle after char_start.
	output logic [9:0]      char_out,   // Character at the locked offset.
	output logic            locked      // Offset confirmed.
);
	localparam int OFF_W = $clog2(SKEW_BITS + 1);

	logic [9:0]             sh_r;
	logic [9:0]             cur_r;
	logic [9:0]             prev_r;
	logic [19:0]            win;
	logic [OFF_W-1:0]       off_r;
	logic [OFF_W-1:0]       cand_r;
	logic [OFF_W-1:0]       hit_off;
	logic                   hit;
	srd_lock_t              state_r;

	// ------------------------------
	// Deserialiser
	// ------------------------------
	// New bits enter at the top, so the first bit ends in bit 0.
	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			sh_r   <= '0;
			cur_r  <= '0;
			prev_r <= '0;
		end else begin
			sh_r <= {bit_in, sh_r[9:1]};
			if (char_start) begin
				cur_r  <= sh_r;
				prev_r <= cur_r;
			end
		end
	end

	// ------------------------------
	// Token search and alignment
	// ------------------------------
	// The lowest offset that shows a blanking token wins.
	assign win = {cur_r, prev_r};
	always_comb begin
		hit     = 1'b0;
		hit_off = '0;
		for (int k = SKEW_BITS; k >= 0; k--) begin
			if (srd_is_ctl(win[k +: CHAR_BITS])) begin
				hit     = 1'b1;
				hit_off = OFF_W'(k);
			end
		end
	end

	// An offset is adopted after two tokens agree on it.
	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			state_r <= LK_SEARCH;
			off_r   <= '0;
			cand_r  <= '0;
		end else if (char_tick && hit) begin
			case (state_r)
				LK_SEARCH: begin
					state_r <= LK_CONFIRM;
					cand_r  <= hit_off;
				end
				LK_CONFIRM: begin
					if (hit_off == cand_r) begin
						state_r <= LK_LOCKED;
						off_r   <= cand_r;
					end else begin
						cand_r <= hit_off;
					end
				end
				default: begin
					if (hit_off != off_r) begin
						state_r <= LK_CONFIRM;
						cand_r  <= hit_off;
					end
				end
			endcase
		end
	end

	assign char_out = win[off_r +: CHAR_BITS];
	assign locked   = (state_r == LK_LOCKED);

	// ------------------------------
	// Checks
	// ------------------------------
	chk_lock_confirm: assert property (@(posedge lclk) disable iff (!lrst_n)
		char_tick && hit && state_r == LK_CONFIRM && hit_off == cand_r
		|=> locked && off_r == $past(cand_r))
		else $error("lane did not lock on a repeated token");
	chk_relock_blank: assert property (@(posedge lclk) disable iff (!lrst_n)
		char_tick && hit && locked && hit_off != off_r
		|=> state_r == LK_CONFIRM && cand_r == $past(hit_off))
		else $error("lane ignored a moved blanking token");

endmodule : srd_lane
`default_nettype wire

// File: hw/srd_top.sv
// Serial RGB input destuffer: frames three colour lanes on the link
// clock, aligns them, drops fill slots and drives bypass DAC codes.
// Assumes lane_clk is the bit clock, ten edges per forwarded clock
// period, and that clk runs freely with nrst from the device reset.
`timescale 1ns/100ps
`default_nettype none
module srd_top
	import srd_pkg::*;
#(
	parameter int SKEW_BITS = SKEW_BITS_DEF // Tolerated lane skew, bits.
) (
	input  wire logic       clk,                   // System clock.
	input  wire logic       nrst,                  // Reset, active low.
	input  wire logic       lane_clk,              // Link bit clock.
	input  wire logic       fwd_clock_pos,         // Forwarded clock leg.
	input  wire logic       red_lane_pair,         // Red serial lane.
	input  wire logic       green_lane_pair,       // Green serial lane.
	input  wire logic       blue_lane_pair,        // Blue serial lane.
	input  wire logic [1:0] mult_sel,              // Clock to pixel ratio.
	input  wire logic       dac_gain_sel,          // 1 selects 0.7V.
	output logic [9:0]      analog_out_channels_0, // Blue DAC code.
	output logic [9:0]      analog_out_channels_1, // Green DAC code.
	output logic [9:0]      analog_out_channels_2, // Red DAC code.
	output logic            dac_full_swing,        // 1 for 0.7V swing.
	output logic            hsync_out,             // Buffered hsync.
	output logic            vsync_out,             // Buffered vsync.
	output logic            active_video_flag,     // Data enable.
	output logic            pix_valid,             // New pixel strobe.
	output logic            rx_locked,             // All lanes locked.
	output logic            frame_err              // Bad boundary spacing.
);

	// ------------------------------
	// Elaboration checks
	// ------------------------------
	// The search window is two characters wide.
	if (SKEW_BITS < 1 || SKEW_BITS > CHAR_BITS - 1) begin : g_bad_skew
		$error("SKEW_BITS must lie between 1 and 9");
	end

	// ------------------------------
	// Declarations
	// ------------------------------
	logic                   lrst_s1_r;
	logic                   lrst_s2_r;
	logic                   link_rst_n;
	logic                   fck_d1_r;
	logic                   fck_d2_r;
	logic                   red_d_r;
	logic                   grn_d_r;
	logic                   blu_d_r;
	logic                   fall;
	logic                   fall_q_r;
	logic                   seen_r;
	logic [3:0]             bitcnt_r;
	logic                   err_l_r;
	logic [9:0]             red_al;
	logic [9:0]             grn_al;
	logic [9:0]             blu_al;
	logic                   red_lk;
	logic                   grn_lk;
	logic                   blu_lk;
	logic [31:0]            xfer_r;
	logic                   tog_r;
	logic                   tog_s1_r;
	logic                   tog_s2_r;
	logic                   tog_s3_r;
	logic                   char_evt;
	logic [2:0]             cfg_s1_r;
	logic [2:0]             cfg_s2_r;
	logic [2:0]             cfg_s3_r;
	logic [1:0]             mult_r;
	logic [1:0]             slot_last;
	logic [1:0]             phase_r;
	logic [1:0]             slot;
	logic [1:0]             phase_nxt;
	logic [9:0]             x_blu;
	logic [9:0]             x_grn;
	logic [9:0]             x_red;
	logic                   x_lock;
	logic                   x_err;
	logic                   b_ctl;
	logic                   b_fill;
	logic                   data_slot;
	logic [7:0]             dec_b;
	logic [7:0]             dec_g;
	logic [7:0]             dec_r;

	// ------------------------------
	// Link reset
	// ------------------------------
	// Reset asserts at once and releases on a link clock edge.
	always_ff @(posedge lane_clk or negedge nrst) begin
		if (!nrst) begin
			lrst_s1_r <= 1'b0;
			lrst_s2_r <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_s2_r <= lrst_s1_r;
		end
	end
	assign link_rst_n = lrst_s2_r;

	// ------------------------------
	// Link pins and character framing
	// ------------------------------
	// Lane pins and the clock leg share a source, so one stage aligns
	// them; a second stage on the clock leg finds its falling edge.
	always_ff @(posedge lane_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fck_d1_r <= 1'b0;
			fck_d2_r <= 1'b0;
			red_d_r  <= 1'b0;
			grn_d_r  <= 1'b0;
			blu_d_r  <= 1'b0;
			fall_q_r <= 1'b0;
		end else begin
			fck_d1_r <= fwd_clock_pos;
			fck_d2_r <= fck_d1_r;
			red_d_r  <= red_lane_pair;
			grn_d_r  <= green_lane_pair;
			blu_d_r  <= blue_lane_pair;
			fall_q_r <= fall;
		end
	end
	assign fall = fck_d2_r & ~fck_d1_r;

	// Counts bits between boundaries; a gap other than ten bits is
	// flagged until the next good boundary. The first one is not judged.
	always_ff @(posedge lane_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bitcnt_r <= '0;
			seen_r   <= 1'b0;
			err_l_r  <= 1'b0;
		end else if (fall) begin
			bitcnt_r <= '0;
			seen_r   <= 1'b1;
			err_l_r  <= seen_r && (bitcnt_r != BIT_LAST);
		end else if (bitcnt_r != BIT_SAT) begin
			bitcnt_r <= bitcnt_r + 4'h1;
		end
	end

	// ------------------------------
	// Lane aligners
	// ------------------------------
	srd_lane #(.SKEW_BITS(SKEW_BITS)) u_lane_red (
		.lclk       (lane_clk),
		.lrst_n     (link_rst_n),
		.bit_in     (red_d_r),
		.char_start (fall),
		.char_tick  (fall_q_r),
		.char_out   (red_al),
		.locked     (red_lk)
	);
	srd_lane #(.SKEW_BITS(SKEW_BITS)) u_lane_grn (
		.lclk       (lane_clk),
		.lrst_n     (link_rst_n),
		.bit_in     (grn_d_r),
		.char_start (fall),
		.char_tick  (fall_q_r),
		.char_out   (grn_al),
		.locked     (grn_lk)
	);
	srd_lane #(.SKEW_BITS(SKEW_BITS)) u_lane_blu (
		.lclk       (lane_clk),
		.lrst_n     (link_rst_n),
		.bit_in     (blu_d_r),
		.char_start (fall),
		.char_tick  (fall_q_r),
		.char_out   (blu_al),
		.locked     (blu_lk)
	);

	// ------------------------------
	// Crossing to the system clock
	// ------------------------------
	// One word per character, held for a full character time; the
	// toggle tells the system side that a new word stands.
	always_ff @(posedge lane_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			xfer_r <= '0;
			tog_r  <= 1'b0;
		end else if (fall_q_r) begin
			xfer_r <= {err_l_r, red_lk & grn_lk & blu_lk,
				red_al, grn_al, blu_al};
			tog_r  <= ~tog_r;
		end
	end

	// Toggle synchroniser; the third stage only serves edge detection.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
		end else begin
			tog_s1_r <= tog_r;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
		end
	end
	assign char_evt = tog_s2_r ^ tog_s3_r;

	assign x_err  = xfer_r[31];
	assign x_lock = xfer_r[30];
	assign x_red  = xfer_r[29:20];
	assign x_grn  = xfer_r[19:10];
	assign x_blu  = xfer_r[9:0];

	// ------------------------------
	// Configuration pins
	// ------------------------------
	// Three stages; a change is taken once stages two and three agree.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_s1_r       <= '0;
			cfg_s2_r       <= '0;
			cfg_s3_r       <= '0;
			mult_r         <= MULT_1X;
			dac_full_swing <= 1'b0;
		end else begin
			cfg_s1_r <= {mult_sel, dac_gain_sel};
			cfg_s2_r <= cfg_s1_r;
			cfg_s3_r <= cfg_s2_r;
			if (cfg_s2_r == cfg_s3_r) begin
				mult_r         <= cfg_s3_r[2:1];
				dac_full_swing <= cfg_s3_r[0];
			end
		end
	end

	// Last slot of a group; an unlisted code behaves as one times.
	always_comb begin
		case (mult_r)
			MULT_4X: slot_last = SLOT_LAST_4X;
			MULT_2X: slot_last = SLOT_LAST_2X;
			default: slot_last = SLOT_LAST_1X;
		endcase
	end

	// ------------------------------
	// Slot phase and fill removal
	// ------------------------------
	// A blanking token always sits in a data slot, so it resets the
	// group phase; fill is never a pixel whatever the phase says.
	assign b_ctl     = srd_is_ctl(x_blu);
	assign b_fill    = (x_blu == FILL_CHAR);
	assign slot      = b_ctl ? 2'h0 : phase_r;
	assign phase_nxt = (slot == slot_last) ? 2'h0 : slot + 2'h1;
	assign data_slot = (slot == 2'h0) && !b_fill && x_lock;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_r <= 2'h0;
		end else if (char_evt) begin
			phase_r <= phase_nxt;
		end
	end

	// ------------------------------
	// Decode and bypass outputs
	// ------------------------------
	assign dec_b = srd_decode(x_blu);
	assign dec_g = srd_decode(x_grn);
	assign dec_r = srd_decode(x_red);

	// Colour goes straight to the DACs in the upper eight code bits.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			analog_out_channels_0 <= '0;
			analog_out_channels_1 <= '0;
			analog_out_channels_2 <= '0;
			pix_valid             <= 1'b0;
		end else begin
			pix_valid <= char_evt && data_slot && !b_ctl;
			if (char_evt && data_slot && !b_ctl) begin
				analog_out_channels_0 <= {dec_b, DAC_PAD};
				analog_out_channels_1 <= {dec_g, DAC_PAD};
				analog_out_channels_2 <= {dec_r, DAC_PAD};
			end
		end
	end

	// Syncs follow blanking tokens; enable marks colour characters.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hsync_out         <= 1'b0;
			vsync_out         <= 1'b0;
			active_video_flag <= 1'b0;
		end else if (char_evt) begin
			if (!x_lock) begin
				active_video_flag <= 1'b0;
			end else if (data_slot && b_ctl) begin
				{vsync_out, hsync_out} <= srd_ctl_vh(x_blu);
				active_video_flag      <= 1'b0;
			end else if (data_slot) begin
				active_video_flag <= 1'b1;
			end
		end
	end

	// Link status flags, refreshed with every character.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_locked <= 1'b0;
			frame_err <= 1'b0;
		end else if (char_evt) begin
			rx_locked <= x_lock;
			frame_err <= x_err;
		end
	end

	// ------------------------------
	// Checks
	// ------------------------------
	default clocking cb_sys @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_pix_evt;
		char_evt && data_slot && !b_ctl;
	endsequence
	sequence s_tok_evt;
		char_evt && data_slot && b_ctl;
	endsequence

	chk_fill_dropped: assert property (
		char_evt && b_fill |=> !pix_valid)
		else $error("fill character shown as a pixel");
	chk_slot_only: assert property (
		char_evt && slot != 2'h0 |=> !pix_valid)
		else $error("pixel strobe outside the data slot");
	chk_every_slot: assert property (
		char_evt && mult_r == MULT_1X && x_lock && !b_ctl && !b_fill
		|=> pix_valid)
		else $error("one times mode dropped a character");
	chk_four_x_wrap: assert property (
		char_evt && mult_r == MULT_4X && slot == 2'h3 |=> phase_r == 2'h0)
		else $error("four slot group did not wrap");
	chk_two_x_wrap: assert property (
		char_evt && mult_r == MULT_2X && slot == 2'h1 |=> phase_r == 2'h0)
		else $error("two slot group did not wrap");
	chk_blue_chan: assert property (
		s_pix_evt |=> pix_valid && active_video_flag
		&& analog_out_channels_0 == {$past(dec_b), DAC_PAD}
		&& analog_out_channels_2 == {$past(dec_r), DAC_PAD})
		else $error("colour did not reach its DAC channel");
	chk_sync_pass: assert property (
		s_tok_evt |=> {vsync_out, hsync_out} == $past(srd_ctl_vh(x_blu))
		&& !active_video_flag && !pix_valid)
		else $error("sync token not passed to the sync pins");
	chk_frame_len: assert property (
		@(posedge lane_clk) disable iff (!link_rst_n)
		fall && seen_r && bitcnt_r != BIT_LAST |=> err_l_r)
		else $error("short or long character not flagged");

endmodule : srd_top
`default_nettype wire

// File: tb/srd_tx_model.sv
// Transmitter model: serialises three colour lanes and the clock leg.
// Assumes lclk is the bit clock; the bench queues characters by push.
`timescale 1ns/100ps
`default_nettype none
module srd_tx_model
	import srd_pkg::*;
(
	input  wire logic lclk,            // Bit clock.
	output logic      fwd_clock_pos,   // Forwarded clock leg.
	output logic      red_lane_pair,   // Red serial lane.
	output logic      green_lane_pair, // Green serial lane.
	output logic      blue_lane_pair   // Blue serial lane.
);
	logic [29:0] q [$];           // Queued {red, green, blue} characters.
	logic [29:0] cur;             // Character being sent.
	logic [15:0] hist = 16'h0000; // Recent red bits, for lane skew.
	logic        short_req = 1'b0; // Next character is one bit short.
	int          lag = 0;         // Red lane delay in bits.
	int          cnt = 9;         // Bit index within the character.
	int          last = 9;        // Last bit index of this character.
	int          idle = 0;        // Idle fills sent since the queue ran dry.

	// Outputs start low so the pins are never unknown.
	initial begin
		fwd_clock_pos = 1'b0;
		red_lane_pair = 1'b0;
		green_lane_pair = 1'b0;
		blue_lane_pair = 1'b0;
	end

	// Queues one character per lane.
	task automatic push(input logic [9:0] b, input logic [9:0] g,
		input logic [9:0] r);
		q.push_back({r, g, b});
	endtask : push

	// Sends one bit per lane each bit clock; idles on fill characters.
	always @(posedge lclk) begin
		if (cnt >= last) begin
			cnt = 0;
			last = short_req ? 8 : 9;
			short_req = 1'b0;
			idle = (q.size() > 0) ? 0 : idle + 1;
			cur = (q.size() > 0) ? q.pop_front() : {3{FILL_CHAR}};
		end else begin
			cnt = cnt + 1;
		end
		hist = {hist[14:0], cur[20 + cnt]};
		blue_lane_pair <= cur[cnt];
		green_lane_pair <= cur[10 + cnt];
		red_lane_pair <= hist[lag];
		fwd_clock_pos <= (cnt >= 5);
	end
endmodule : srd_tx_model
`default_nettype wire

// File: tb/srd_top_tb.sv
// Self-checking bench for the serial RGB destuffer top.
// Assumes the transmitter model drives the link pins on lane_clk.
`timescale 1ns/100ps
`default_nettype none
module srd_top_tb
	import srd_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        lane_clk = 1'b0;
	logic [1:0]  mult_sel = 2'h0;
	logic        dac_gain_sel = 1'b0;
	logic        fwd, red, green, blue;
	logic [9:0]  ch0, ch1, ch2;
	logic        full, hs, vs, act, pv, lk, ferr;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          slots = 1;
	logic [29:0] got [$];
	logic [7:0]  vals [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
	// Code 2'h2 is unlisted and must behave as one times.
	logic [1:0]  mults [4] = '{MULT_1X, MULT_2X, MULT_4X, 2'h2};
	int          slot_tab [4] = '{1, 2, 4, 1};
	int          lag_tab [4] = '{0, 1, 3, 0};

	// System clock and an unrelated bit clock.
	always #20 clk = ~clk;
	initial begin
		#7;
		forever #80 lane_clk = ~lane_clk;
	end

	srd_top i_dut (
		.clk(clk), .nrst(nrst), .lane_clk(lane_clk),
		.fwd_clock_pos(fwd), .red_lane_pair(red),
		.green_lane_pair(green), .blue_lane_pair(blue),
		.mult_sel(mult_sel), .dac_gain_sel(dac_gain_sel),
		.analog_out_channels_0(ch0), .analog_out_channels_1(ch1),
		.analog_out_channels_2(ch2), .dac_full_swing(full),
		.hsync_out(hs), .vsync_out(vs), .active_video_flag(act),
		.pix_valid(pv), .rx_locked(lk), .frame_err(ferr)
	);

	srd_tx_model i_tx (
		.lclk(lane_clk), .fwd_clock_pos(fwd), .red_lane_pair(red),
		.green_lane_pair(green), .blue_lane_pair(blue)
	);

	// Compares a single flag.
	task automatic cmp1(input logic got_v, input logic exp_v);
		samples_checked++;
		if (got_v !== exp_v) begin
			err_count++;
			$display("mismatch at %0t: flag %b, want %b", $time, got_v, exp_v);
		end
	endtask : cmp1

	// Compares a ten-bit code.
	task automatic cmp10(input logic [9:0] got_v, input logic [9:0] exp_v);
		samples_checked++;
		if (got_v !== exp_v) begin
			err_count++;
			$display("mismatch at %0t: code %h, want %h", $time, got_v, exp_v);
		end
	endtask : cmp10

	// Prints the verdict and ends the run.
	task automatic summarize();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// Encodes a pixel with the xor chain and no inversion.
	function automatic logic [9:0] enc(input logic [7:0] p);
		logic [7:0] d;
		d[0] = p[0];
		for (int i = 1; i < 8; i++) begin
			d[i] = p[i] ^ d[i-1];
		end
		return {2'b01, d};
	endfunction : enc

	// Records every pixel strobe with its DAC codes, away from the edge.
	always @(negedge clk) begin
		if (pv === 1'b1) begin
			got.push_back({ch2, ch1, ch0});
			cmp1(act, 1'b1);
		end
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			summarize();
		end
	end

	// Resets with a chosen multiplier, gain and red lane delay.
	task automatic do_reset(input int idx);
		@(posedge clk);
		nrst <= 1'b0;
		mult_sel <= mults[idx];
		dac_gain_sel <= idx[0];
		slots = slot_tab[idx];
		i_tx.lag = lag_tab[idx];
		repeat (16) @(posedge clk);
		cmp1(pv | lk | act | hs | vs | ferr, 1'b0);
		cmp10(ch0 | ch1 | ch2, 10'h000);
		nrst <= 1'b1;
	endtask : do_reset

	// Queues one slot group: the character then its fills.
	task automatic push_slot(input logic [9:0] b, input logic [9:0] g,
		input logic [9:0] r);
		i_tx.push(b, g, r);
		for (int k = 1; k < slots; k++) begin
			i_tx.push(FILL_CHAR, FILL_CHAR, FILL_CHAR);
		end
	endtask : push_slot

	// Queues pixel i with distinct values per lane. Red avoids an inverted
	// zero, whose code mimics a blanking token two bits early.
	task automatic push_pix(input int i);
		push_slot(enc(vals[i]), enc(vals[i] ^ 8'h3C), enc(vals[i] ^ 8'hC3));
	endtask : push_pix

	// Waits until the model has sent all, then for eight idle fills, so
	// results have landed and the next group starts on a group boundary.
	task automatic drain();
		int n;
		n = 0;
		while ((i_tx.q.size() != 0 || i_tx.idle < 8) && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) begin
			err_count++;
			$display("mismatch at %0t: link model stalled", $time);
		end
	endtask : drain

	// Locks, sends pixels around a pair of blanking tokens and checks every output.
	task automatic run_mode(input int idx);
		logic [7:0] v;
		logic [9:0] tok;
		tok = (idx == 0) ? CTL_V0H1 : (idx == 1) ? CTL_V1H0 : CTL_V1H1;
		do_reset(idx);
		got.delete();
		repeat (3) push_slot(CTL_V0H0, CTL_V0H0, CTL_V0H0);
		drain();
		cmp1(lk, 1'b1);
		cmp1(hs | vs | act, 1'b0);
		push_pix(0);
		push_pix(1);
		repeat (2) push_slot(tok, tok, tok);
		push_pix(2);
		push_pix(3);
		push_slot(tok, tok, tok);
		drain();
		cmp1(lk, 1'b1);
		cmp1(full, idx[0]);
		cmp1(hs, idx != 1);
		cmp1(vs, idx > 0);
		cmp1(act, 1'b0);
		cmp1(ferr, 1'b0);
		cmp10(10'(got.size()), 10'h004);
		for (int i = 0; i < 4 && i < got.size(); i++) begin
			v = vals[i];
			cmp10(got[i][9:0], {v, DAC_PAD});
			cmp10(got[i][19:10], {v ^ 8'h3C, DAC_PAD});
			cmp10(got[i][29:20], {v ^ 8'hC3, DAC_PAD});
		end
	endtask : run_mode

	// Sends one short character and expects a boundary spacing error.
	task automatic short_char();
		logic seen;
		seen = 1'b0;
		i_tx.short_req = 1'b1;
		repeat (200) begin
			@(posedge clk);
			seen = seen | (ferr === 1'b1);
		end
		cmp1(seen, 1'b1);
		repeat (100) @(posedge clk);
		cmp1(ferr, 1'b0);
	endtask : short_char

	// Main sequence over all four multiplier codes.
	initial begin
		for (int i = 0; i < 4; i++) begin
			run_mode(i);
		end
		short_char();
		summarize();
	end
endmodule : srd_top_tb
`default_nettype wire
